/* core_regs_defines.vh */
// Constants for the core status, option and interrupt control registers
// Summary of operation
// - Flag-affecting instruction overrides status flag writes
// - Timeout and power-down bits ignore writes
// - Clear instruction aimed at status zeroes top bits, sets zero
// - Bank select bit picks direct bank
// - Timeout bit set by clear or sleep, cleared by watchdog timeout
// - Power-down bit set by clear, cleared by sleep
// - Zero flag follows result equal zero
// - Digit carry from bit three carry
// - Carry from top bit, no borrow
// - Rotate loads carry with shifted-out bit
// - Pull-up disable bit overrides pin pull-ups
// - Edge select picks external interrupt edge
// - Clock source picks pin or instruction clock
// - Source edge picks falling or rising
// - Assignment bit routes prescaler to watchdog
// - Rate field sets timer, watchdog division
// - Flags set regardless of enables
// - Global and peripheral enables gate interrupts
// - Three enables for timer, pin, change
// - Hardware events set the three flags
`ifndef CORE_REGS_DEFINES_VH
`define CORE_REGS_DEFINES_VH

// ----------------------------------------
// Register indices, byte address is four times
// ----------------------------------------
`define IDX_STATUS_LO 10'h003
`define IDX_STATUS_HI 10'h083
`define IDX_INTCTL_LO 10'h00B
`define IDX_INTCTL_HI 10'h08B
`define IDX_OPTION 10'h081

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_STATUS 8'h18
`define RST_OPTION 8'hFF
`define RST_INTCTL 8'h00

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_BANK 5
`define ST_TIMEOUT 4
`define ST_PWRDN 3
`define ST_ZERO 2
`define ST_DC 1
`define ST_CARRY 0

// ----------------------------------------
// Option fields
// ----------------------------------------
`define OP_PULLDIS 7
`define OP_EDGE 6
`define OP_CLKSRC 5
`define OP_SRCEDGE 4
`define OP_PSA 3

// ----------------------------------------
// Interrupt control fields
// ----------------------------------------
`define IC_GIE 7
`define IC_PERIPHERAL_IRQ_ENABLE 6
`define IC_TIE 5
`define IC_XIE 4
`define IC_CIE 3
`define IC_TIF 2
`define IC_XIF 1
`define IC_CIF 0

// ----------------------------------------
// Instruction flag classes
// ----------------------------------------
`define ALU_ADD 3'h0
`define ALU_SUB 3'h1
`define ALU_LOGIC 3'h2
`define ALU_CLEAR 3'h3
`define ALU_ROTR 3'h4
`define ALU_ROTL 3'h5
`define ALU_NOFLAG 3'h6

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* alu_flag_gen.v */
// Result and flag generation for instructions that write the status flags
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module alu_flag_gen (
  input wire [2:0] op,
  input wire [7:0] opA,
  input wire [7:0] opB,
  input wire carryIn,
  output reg [7:0] result,
  output reg zero,
  output reg digitCarry,
  output reg carry,
  output reg updZero,
  output reg updCarry
);
  reg [8:0] sum;
  reg [4:0] lowSum;
  reg [7:0] addend;
  reg plusOne;

  always @* begin
    plusOne = (op == `ALU_SUB);
    // Subtract adds the two's complement, so carry means no borrow
    addend = plusOne ? ~opB : opB;
    sum = {1'b0, opA} + {1'b0, addend} + {8'h00, plusOne};
    lowSum = {1'b0, opA[3:0]} + {1'b0, addend[3:0]} + {4'h0, plusOne};
    result = opB;
    digitCarry = lowSum[4];
    carry = carryIn;
    updZero = 1'b1;
    updCarry = 1'b0;
    case (op)
      `ALU_ADD, `ALU_SUB: begin
        result = sum[7:0];
        carry = sum[8];
        updCarry = 1'b1;
      end
      `ALU_LOGIC: begin
        result = opB;
      end
      `ALU_CLEAR: begin
        result = 8'h00;
      end
      `ALU_ROTR: begin
        result = {carryIn, opA[7:1]};
        carry = opA[0];
        updZero = 1'b0;
        updCarry = 1'b1;
      end
      `ALU_ROTL: begin
        result = {opA[6:0], carryIn};
        carry = opA[7];
        updZero = 1'b0;
        updCarry = 1'b1;
      end
      default: begin
        updZero = 1'b0;
      end
    endcase
    zero = (result == 8'h00);
  end
endmodule // alu_flag_gen

/* core_status_option_irq_regs.v */
// Status, option and interrupt control registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module core_status_option_irq_regs (
  input wire clock,
  input wire sys_rst,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire instrValid,
  input wire [2:0] instrOp,
  input wire [7:0] instrOpA,
  input wire [7:0] instrOpB,
  input wire instrDestStatus,
  input wire watchdogClearInstr,
  input wire sleepInstr,
  input wire watchdogTimeout,
  input wire timerRollover,
  input wire peripheralIrqPending,
  input wire ext_irq_pin,
  input wire ext_timer_clock_pin,
  input wire [5:0] port_a_pins,
  input wire [5:0] perPinChangeEnable,
  input wire [5:0] pullupLatch,
  input wire instrCycleTick,
  input wire watchdogBaseTick,
  output wire bankSelectLow,
  output reg [7:0] aluResult,
  output reg [5:0] pullupEnable,
  output reg timerIncrement,
  output reg watchdogIncrement,
  output reg irqRequest
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [7:0] statusQ;
  reg [7:0] statusD;
  reg [7:0] optionQ;
  reg [7:0] intctlQ;
  reg [7:0] intctlD;

  // ----------------------------------------
  // AXI write and read channel state
  // ----------------------------------------
  reg awreadyQ;
  reg wreadyQ;
  reg awHeldQ;
  reg wHeldQ;
  reg [9:0] awIndexQ;
  reg [7:0] wDataQ;
  reg wLaneQ;
  reg bvalidQ;
  reg [1:0] brespQ;
  reg arreadyQ;
  reg rvalidQ;
  reg [7:0] rdataQ;
  reg [1:0] rrespQ;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg extIrqMetaQ;
  reg extIrqSyncQ;
  reg extIrqPrevQ;
  reg extClkMetaQ;
  reg extClkSyncQ;
  reg extClkPrevQ;
  reg [5:0] portMetaQ;
  reg [5:0] portSyncQ;
  reg [5:0] portPrevQ;

  reg [7:0] psCntQ;

  wire [7:0] result;
  wire zero;
  wire digitCarry;
  wire carry;
  wire updZero;
  wire updCarry;

  wire doWrite;
  wire wrStatus;
  wire wrOption;
  wire wrIntctl;
  wire arHs;
  wire [9:0] arIndex;
  wire instrStatus;
  wire affectsFlags;
  wire extEdge;
  wire portChange;
  wire extClkRise;
  wire extClkFall;
  wire timerSrcTick;
  wire psSrcTick;
  wire [3:0] psExp;
  wire [8:0] psMaskWide;
  wire psTerminal;
  wire prescaled;
  wire irqD;

  alu_flag_gen aluFlags (
    .op(instrOp),
    .opA(instrOpA),
    .opB(instrOpB),
    .carryIn(statusQ[`ST_CARRY]),
    .result(result),
    .zero(zero),
    .digitCarry(digitCarry),
    .carry(carry),
    .updZero(updZero),
    .updCarry(updCarry)
  );

  function [1:0] decodeIdx;
    input [9:0] idx;
    begin
      if ((idx == `IDX_STATUS_LO) || (idx == `IDX_STATUS_HI)) begin
        decodeIdx = 2'h1;
      end else if ((idx == `IDX_INTCTL_LO) || (idx == `IDX_INTCTL_HI)) begin
        decodeIdx = 2'h2;
      end else if (idx == `IDX_OPTION) begin
        decodeIdx = 2'h3;
      end else begin
        decodeIdx = 2'h0;
      end
    end
  endfunction

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign s_axi_awready = awreadyQ;
  assign s_axi_wready = wreadyQ;
  assign s_axi_bvalid = bvalidQ;
  assign s_axi_bresp = brespQ;
  assign s_axi_arready = arreadyQ;
  assign s_axi_rvalid = rvalidQ;
  assign s_axi_rresp = rrespQ;
  assign s_axi_rdata = {24'h000000, rdataQ};

  assign doWrite = awHeldQ && wHeldQ && !bvalidQ;
  // Lane zero carries the whole register, other lanes only answer
  assign wrStatus = doWrite && wLaneQ && (decodeIdx(awIndexQ) == 2'h1);
  assign wrIntctl = doWrite && wLaneQ && (decodeIdx(awIndexQ) == 2'h2);
  assign wrOption = doWrite && wLaneQ && (decodeIdx(awIndexQ) == 2'h3);
  assign arHs = s_axi_arvalid && arreadyQ;
  assign arIndex = s_axi_araddr[11:2];

  always @(posedge clock) begin
    if (sys_rst) begin
      awreadyQ <= 1'b0;
      wreadyQ <= 1'b0;
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awIndexQ <= 10'h000;
      wDataQ <= 8'h00;
      wLaneQ <= 1'b0;
      bvalidQ <= 1'b0;
      brespQ <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awreadyQ) begin
        awreadyQ <= 1'b0;
        awHeldQ <= 1'b1;
        awIndexQ <= s_axi_awaddr[11:2];
      end else if (!awHeldQ && !bvalidQ) begin
        awreadyQ <= 1'b1;
      end
      if (s_axi_wvalid && wreadyQ) begin
        wreadyQ <= 1'b0;
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata[7:0];
        wLaneQ <= s_axi_wstrb[0];
      end else if (!wHeldQ && !bvalidQ) begin
        wreadyQ <= 1'b1;
      end
      if (doWrite) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        bvalidQ <= 1'b1;
        brespQ <= (decodeIdx(awIndexQ) == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalidQ && s_axi_bready) begin
        bvalidQ <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      arreadyQ <= 1'b0;
      rvalidQ <= 1'b0;
      rdataQ <= 8'h00;
      rrespQ <= `RESP_OKAY;
    end else begin
      if (arHs) begin
        arreadyQ <= 1'b0;
        rvalidQ <= 1'b1;
        rrespQ <= `RESP_OKAY;
        case (decodeIdx(arIndex))
          2'h1: rdataQ <= statusQ;
          2'h2: rdataQ <= intctlQ;
          2'h3: rdataQ <= optionQ;
          default: begin
            rdataQ <= 8'h00;
            rrespQ <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalidQ && s_axi_rready) begin
        rvalidQ <= 1'b0;
      end else if (!rvalidQ) begin
        arreadyQ <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  assign instrStatus = instrValid && instrDestStatus;
  assign affectsFlags = updZero || updCarry;
  assign bankSelectLow = statusQ[`ST_BANK];

  always @* begin
    statusD = statusQ;
    if (wrStatus) begin
      // Top bits are plain storage; software keeps them clear
      statusD[7:5] = wDataQ[7:5];
      statusD[2:0] = wDataQ[2:0];
    end
    if (instrStatus) begin
      statusD[7:5] = result[7:5];
      if (!affectsFlags) begin
        statusD[2:0] = result[2:0];
      end
    end
    if (instrValid && updZero) begin
      statusD[`ST_ZERO] = zero;
    end
    if (instrValid && updCarry) begin
      statusD[`ST_CARRY] = carry;
      if ((instrOp == `ALU_ADD) || (instrOp == `ALU_SUB)) begin
        statusD[`ST_DC] = digitCarry;
      end
    end
    // Hardware events alone move the timeout and power-down bits
    if (watchdogClearInstr) begin
      statusD[`ST_TIMEOUT] = 1'b1;
      statusD[`ST_PWRDN] = 1'b1;
    end else if (sleepInstr) begin
      statusD[`ST_TIMEOUT] = 1'b1;
      statusD[`ST_PWRDN] = 1'b0;
    end
    if (watchdogTimeout) begin
      statusD[`ST_TIMEOUT] = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      statusQ <= `RST_STATUS;
      aluResult <= 8'h00;
    end else begin
      statusQ <= statusD;
      if (instrValid) begin
        aluResult <= result;
      end
    end
  end

  // ----------------------------------------
  // Option register
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      optionQ <= `RST_OPTION;
    end else if (wrOption) begin
      optionQ <= wDataQ;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      pullupEnable <= 6'h00;
    end else begin
      pullupEnable <= optionQ[`OP_PULLDIS] ? 6'h00 : pullupLatch;
    end
  end

  // ----------------------------------------
  // Synchronisers and edge detection
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      extIrqMetaQ <= 1'b0;
      extIrqSyncQ <= 1'b0;
      extIrqPrevQ <= 1'b0;
      extClkMetaQ <= 1'b0;
      extClkSyncQ <= 1'b0;
      extClkPrevQ <= 1'b0;
      portMetaQ <= 6'h00;
      portSyncQ <= 6'h00;
      portPrevQ <= 6'h00;
    end else begin
      extIrqMetaQ <= ext_irq_pin;
      extIrqSyncQ <= extIrqMetaQ;
      extIrqPrevQ <= extIrqSyncQ;
      extClkMetaQ <= ext_timer_clock_pin;
      extClkSyncQ <= extClkMetaQ;
      extClkPrevQ <= extClkSyncQ;
      portMetaQ <= port_a_pins;
      portSyncQ <= portMetaQ;
      portPrevQ <= portSyncQ;
    end
  end

  assign extEdge = optionQ[`OP_EDGE] ? (extIrqSyncQ && !extIrqPrevQ) :
                   (!extIrqSyncQ && extIrqPrevQ);
  assign portChange = |((portSyncQ ^ portPrevQ) & perPinChangeEnable);
  assign extClkRise = extClkSyncQ && !extClkPrevQ;
  assign extClkFall = !extClkSyncQ && extClkPrevQ;

  // ----------------------------------------
  // Shared prescaler
  // ----------------------------------------
  // The pin is sampled, so external pulses shorter than one clock may be lost
  assign timerSrcTick = optionQ[`OP_CLKSRC] ?
                        (optionQ[`OP_SRCEDGE] ? extClkFall : extClkRise) :
                        instrCycleTick;
  assign psSrcTick = optionQ[`OP_PSA] ? watchdogBaseTick : timerSrcTick;
  assign psExp = optionQ[`OP_PSA] ? {1'b0, optionQ[2:0]} :
                 ({1'b0, optionQ[2:0]} + 4'h1);
  assign psMaskWide = (9'h001 << psExp) - 9'h001;
  assign psTerminal = ((psCntQ & psMaskWide[7:0]) == psMaskWide[7:0]);
  assign prescaled = psSrcTick && psTerminal;

  always @(posedge clock) begin
    if (sys_rst) begin
      psCntQ <= 8'h00;
      timerIncrement <= 1'b0;
      watchdogIncrement <= 1'b0;
    end else begin
      // Reassignment restarts the count so no stale partial period leaks
      if (wrOption || prescaled) begin
        psCntQ <= 8'h00;
      end else if (psSrcTick) begin
        psCntQ <= psCntQ + 8'h01;
      end
      // Undivided timer only when the prescaler sits on the watchdog
      timerIncrement <= optionQ[`OP_PSA] ? timerSrcTick : prescaled;
      watchdogIncrement <= optionQ[`OP_PSA] ? prescaled : watchdogBaseTick;
    end
  end

  // ----------------------------------------
  // Interrupt control register
  // ----------------------------------------
  always @* begin
    intctlD = intctlQ;
    if (wrIntctl) begin
      intctlD = wDataQ;
    end
    // Set wins over a clear in the same cycle, enables play no part
    if (timerRollover) begin
      intctlD[`IC_TIF] = 1'b1;
    end
    if (extEdge) begin
      intctlD[`IC_XIF] = 1'b1;
    end
    if (portChange) begin
      intctlD[`IC_CIF] = 1'b1;
    end
  end

  assign irqD = intctlQ[`IC_GIE] && (
                (intctlQ[`IC_TIE] && intctlQ[`IC_TIF]) ||
                (intctlQ[`IC_XIE] && intctlQ[`IC_XIF]) ||
                (intctlQ[`IC_CIE] && intctlQ[`IC_CIF]) ||
                (intctlQ[`IC_PERIPHERAL_IRQ_ENABLE] && peripheralIrqPending));

  always @(posedge clock) begin
    if (sys_rst) begin
      intctlQ <= `RST_INTCTL;
      irqRequest <= 1'b0;
    end else begin
      intctlQ <= intctlD;
      irqRequest <= irqD;
    end
  end
endmodule // core_status_option_irq_regs

/* core_regs_checker_assertions.sv */
// Port-level assertions for the core status, option and interrupt block
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module core_regs_checker (
  input logic clock,
  input logic sys_rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic instrValid,
  input logic [2:0] instrOp,
  input logic [7:0] instrOpA,
  input logic [7:0] instrOpB,
  input logic [7:0] aluResult,
  input logic [5:0] pullupLatch,
  input logic [5:0] pullupEnable,
  input logic watchdogBaseTick,
  input logic watchdogIncrement
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_instr(logic [2:0] op);
    instrValid && instrOp == op;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_write_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer missing");
  property p_bresp_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");
  property p_read_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
  property p_clear; s_instr(`ALU_CLEAR) |=> aluResult == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("clear result not zero");
  property p_logic; s_instr(`ALU_LOGIC) |=> aluResult == $past(instrOpB); endproperty
  a_logic: assert property (p_logic) else $error("logic result wrong");
  property p_add; s_instr(`ALU_ADD) |=> aluResult == $past(instrOpA) + $past(instrOpB); endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_rotr; s_instr(`ALU_ROTR) |=> {1'b0, aluResult[6:0]} == ($past(instrOpA) >> 1); endproperty
  a_rotr: assert property (p_rotr) else $error("rotate result wrong");
  property p_pullup; pullupEnable != 6'h00 |-> pullupEnable == $past(pullupLatch); endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not from latch");
  property p_wdog; watchdogIncrement |-> $past(watchdogBaseTick); endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog step without tick");
endmodule // core_regs_checker

bind core_status_option_irq_regs core_regs_checker i_chk (.*);

/* core_status_option_irq_regs_tb.sv */
// Self-checking bench for the core status, option and interrupt block
`timescale 1ns/1ps
`include "core_regs_defines.vh"
module core_status_option_irq_regs_tb;
  localparam [11:0] A_ST = {`IDX_STATUS_LO, 2'b00};
  localparam [11:0] A_STH = {`IDX_STATUS_HI, 2'b00};
  localparam [11:0] A_IC = {`IDX_INTCTL_LO, 2'b00};
  localparam [11:0] A_ICH = {`IDX_INTCTL_HI, 2'b00};
  localparam [11:0] A_OP = {`IDX_OPTION, 2'b00};
  reg clock = 1'b0, sys_rst = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg instrValid = 1'b0, instrDestStatus = 1'b0, watchdogClearInstr = 1'b0, sleepInstr = 1'b0;
  reg watchdogTimeout = 1'b0, timerRollover = 1'b0, peripheralIrqPending = 1'b0;
  reg ext_irq_pin = 1'b0, ext_timer_clock_pin = 1'b0, instrCycleTick = 1'b0;
  reg watchdogBaseTick = 1'b0, ivSeen = 1'b0;
  reg [2:0] instrOp = 3'h0;
  reg [7:0] instrOpA = 8'h00, instrOpB = 8'h00;
  reg [5:0] port_a_pins = 6'h00, perPinChangeEnable = 6'h01, pullupLatch = 6'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] aluResult;
  wire [5:0] pullupEnable;
  wire bankSelectLow, timerIncrement, watchdogIncrement, irqRequest;
  reg [7:0] st, tCnt, wCnt, o, et, ew;
  integer errCount = 0, nCompared = 0, i, k;
  reg [33:0] rq[$];
  reg [1:0] wq[$];
  reg [7:0] aq[$];
  core_status_option_irq_regs i_dut (.*);
  always #4 clock = ~clock;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input [33:0] seen, input [33:0] exp, input string what);
    begin
      nCompared = nCompared + 1;
      if (seen !== exp) begin
        errCount = errCount + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      if (errCount == 0 && nCompared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // Address and data go out together; each is dropped on its own ready
  task wr(input [11:0] a, input [7:0] d, input [1:0] er = `RESP_OKAY);
    begin
      wq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      w($urandom % 3);
      s_axi_bready <= 1'b1;
      do @(posedge clock); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e, input [1:0] er = `RESP_OKAY);
    begin
      rq.push_back({er, 24'h000000, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clock); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      w($urandom % 3);
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
    end
  endtask
  // Leaves instrValid high so calls can run back to back
  task alu(input [2:0] op, input [7:0] a, input [7:0] b, input d);
    reg [8:0] s;
    reg [7:0] r;
    begin
      s = {1'b0, a} + {1'b0, b};
      case (op)
        `ALU_ADD: begin r = s[7:0]; st[0] = s[8]; st[1] = a[3:0] + b[3:0] > 5'h0F; end
        `ALU_SUB: begin r = a - b; st[0] = a >= b; st[1] = a[3:0] >= b[3:0]; end
        `ALU_LOGIC: r = b;
        `ALU_ROTR: begin r = {st[0], a[7:1]}; st[0] = a[0]; end
        `ALU_ROTL: begin r = {a[6:0], st[0]}; st[0] = a[7]; end
        default: r = 8'h00;
      endcase
      if (op <= `ALU_CLEAR) st[2] = r == 8'h00;
      if (d && op == `ALU_CLEAR) st[7:5] = 3'h0;
      if (op != `ALU_NOFLAG) aq.push_back(r);
      {instrValid, instrDestStatus, instrOp, instrOpA, instrOpB} <= {1'b1, d, op, a, b};
      @(posedge clock);
    end
  endtask
  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge clock) begin
    if (ivSeen) check(aluResult, aq.pop_front(), "alu");
    ivSeen <= instrValid && instrOp != `ALU_NOFLAG;
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, wq.pop_front(), "bresp");
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "rd");
    if (timerIncrement) tCnt <= tCnt + 8'h01;
    if (watchdogIncrement) wCnt <= wCnt + 8'h01;
  end
  initial begin
    #200000;
    errCount = errCount + 1;
    close_out;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    st = `RST_STATUS;
    w(16);
    sys_rst <= 1'b0;
    void'($urandom(32'h59E8));
    w(2);
    rd(A_ST, `RST_STATUS);
    rd(A_STH, `RST_STATUS);
    rd(A_IC, `RST_INTCTL);
    rd(A_OP, `RST_OPTION);
    rd(12'h100, 8'h00, `RESP_SLVERR);
    wr(12'h100, 8'hFF, `RESP_SLVERR);
    wr(A_ST, 8'h27);
    st = 8'h3F;
    rd(A_STH, st);
    check(bankSelectLow, 1'b1, "bank");
    alu(`ALU_CLEAR, 8'h5A, 8'hA5, 1'b1);
    instrValid <= 1'b0;
    rd(A_ST, st);
    check(bankSelectLow, 1'b0, "bank");
    for (i = 0; i < 3; i = i + 1) begin
      {watchdogTimeout, sleepInstr, watchdogClearInstr} <= i == 0 ? 3'h2 : i == 1 ? 3'h4 : 3'h1;
      w(1);
      {watchdogTimeout, sleepInstr, watchdogClearInstr} <= 3'h0;
      st[4:3] = i == 0 ? 2'b10 : i == 1 ? {1'b0, st[3]} : 2'b11;
      rd(A_ST, st);
    end
    alu(`ALU_SUB, 8'h3C, 8'h3C, 1'b0);
    alu(`ALU_ADD, 8'hFF, 8'h01, 1'b0);
    for (i = 0; i < 20; i = i + 1) begin
      alu($urandom % 7, $urandom, $urandom, 1'b0);
      alu($urandom % 7, $urandom, $urandom, 1'b0);
      instrValid <= 1'b0;
      rd(A_ST, st);
    end
    pullupLatch <= $urandom;
    for (i = 0; i < 6; i = i + 1) begin
      case (i)
        0: {o, et, ew} = {8'h88, 8'h20, 8'h20};
        1: {o, et, ew} = {8'h0A, 8'h20, 8'h08};
        2: {o, et, ew} = {8'h00, 8'h10, 8'h20};
        3: {o, et, ew} = {8'h07, 8'h00, 8'h20};
        4: {o, et, ew} = {8'h28, 8'h10, 8'h20};
        default: {o, et, ew} = {8'h38, 8'h0F, 8'h20};
      endcase
      ext_timer_clock_pin <= 1'b0;
      wr(A_OP, o);
      w(6);
      tCnt = 8'h00;
      wCnt = 8'h00;
      for (k = 0; k < 32; k = k + 1) begin
        {instrCycleTick, watchdogBaseTick} <= 2'h3;
        if (k > 0) ext_timer_clock_pin <= ~ext_timer_clock_pin;
        w(1);
        {instrCycleTick, watchdogBaseTick} <= 2'h0;
        w(1);
      end
      w(8);
      check(tCnt, et, "timer steps");
      check(wCnt, ew, "watchdog steps");
      check(pullupEnable, o[7] ? 6'h00 : pullupLatch, "pullup");
    end
    wr(A_IC, 8'h00);
    timerRollover <= 1'b1;
    w(1);
    timerRollover <= 1'b0;
    rd(A_IC, 8'h04);
    check(irqRequest, 1'b0, "irq");
    wr(A_ICH, 8'hA4);
    w(3);
    check(irqRequest, 1'b1, "irq");
    wr(A_IC, 8'h20);
    wr(A_OP, 8'h40);
    ext_irq_pin <= 1'b1;
    w(8);
    rd(A_ICH, 8'h22);
    wr(A_IC, 8'h00);
    ext_irq_pin <= 1'b0;
    port_a_pins <= 6'h02;
    w(8);
    rd(A_IC, 8'h00);
    port_a_pins <= 6'h03;
    w(8);
    rd(A_IC, 8'h01);
    wr(A_IC, 8'h00);
    peripheralIrqPending <= 1'b1;
    wr(A_IC, 8'h80);
    w(3);
    check(irqRequest, 1'b0, "irq");
    wr(A_IC, 8'hC0);
    w(3);
    check(irqRequest, 1'b1, "irq");
    close_out;
  end
endmodule // core_status_option_irq_regs_tb
